/* File: rtl/mas_pkg.sv */
package mas_pkg;
    // Clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int GLITCH_US = 64;
    localparam int GLITCH_CYC = (GLITCH_US * (CLK_HZ / 1_000_000) > 0) ? GLITCH_US * (CLK_HZ / 1_000_000) : 1;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SCHED_US = 1000;
    localparam int SCHED_CYC_DEF = SCHED_US * (CLK_HZ / 1_000_000);

    // High-voltage monitor trip levels
    localparam int HV_TRIP_W = 9;
    localparam logic [HV_TRIP_W-1:0] HV_TRIP_MAX = 9'h197;
    localparam logic [HV_TRIP_W-1:0] HV_HYST_MIN_DEF = 9'h028;

    // Converter
    localparam int ADC_W = 10;
    localparam int RES_W = 13;
    localparam int RES_HI_W = 8;
    localparam int RES_LO_W = 5;
    localparam int VSUB_W = 4;
    localparam logic [1:0] SRC_HV_CUR = 2'h0;
    localparam logic [1:0] SRC_LV_CUR = 2'h1;
    localparam logic [1:0] SRC_HV_MON = 2'h2;
    localparam logic [1:0] SRC_VOLTAGE_MONITOR_INPUT = 2'h3;
    localparam int AVG_SHIFT = 3;
    localparam int ACC_W = RES_W + AVG_SHIFT;
    localparam int CUR_CH = 2;

    // Temperature
    localparam int TEMP_CH = 3;
    localparam int TRAW_W = 12;
    localparam int TEMP_W = 11;
    localparam int IDEAL_W = 16;
    localparam int IDEAL_FRAC = 14;
    localparam int TOFS_W = 9;
    localparam int TWIDE_W = 32;
    localparam logic signed [TWIDE_W-1:0] KELVIN_Q = 32'sh0000_0445;
    localparam logic signed [TWIDE_W-1:0] TEMP_MAX = 32'sh0000_03ff;
    localparam logic signed [TWIDE_W-1:0] TEMP_MIN = -32'sh0000_0400;
    localparam logic [1:0] SENS_BETA_PNP = 2'h0;
    localparam logic [1:0] SENS_DIFF = 2'h1;
    localparam logic [1:0] SENS_SINGLE = 2'h2;
endpackage : mas_pkg

/* File: rtl/mas_glitch_filter.sv */
`timescale 1ns/1ps
module mas_glitch_filter
    import mas_pkg::*;
#(
    parameter int FILT_CYC = GLITCH_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Comparator
    input wire logic raw_i,
    input wire logic filt_en_i,
    output logic flag_o
);
    localparam int CNT_W = $clog2(FILT_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYC - 1);

    logic sync1_reg;
    logic sync2_reg;
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Any return to the held level restarts the persistence count
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
            flag_o <= 1'b0;
        end else if (!filt_en_i) begin
            cnt_reg <= '0;
            flag_o <= sync2_reg;
        end else if (sync2_reg == flag_o) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CNT_LAST) begin
            cnt_reg <= '0;
            flag_o <= sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule : mas_glitch_filter

/* File: rtl/mas_temp_conv.sv */
`timescale 1ns/1ps
module mas_temp_conv
    import mas_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Sample from the temperature converter, quarter degrees at unity ideality
    input wire logic sample_valid_i,
    input wire logic signed [TRAW_W-1:0] sample_i,
    // Channel setup
    input wire logic [IDEAL_W-1:0] ideality_recip_i,
    input wire logic signed [TOFS_W-1:0] offset_i,
    // Reading
    output logic valid_o,
    output logic signed [TEMP_W-1:0] reading_o
);
    logic signed [TWIDE_W-1:0] kelvin;
    logic signed [TWIDE_W-1:0] prod;
    logic signed [TWIDE_W-1:0] celsius;

    // Error scales with absolute temperature, so correct in kelvin
    always_comb begin
        kelvin = TWIDE_W'(sample_i) + KELVIN_Q;
        prod = (kelvin * $signed({1'b0, ideality_recip_i})) >>> IDEAL_FRAC;
        celsius = prod - KELVIN_Q + TWIDE_W'(offset_i);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_o <= 1'b0;
            reading_o <= '0;
        end else begin
            valid_o <= sample_valid_i;
            if (sample_valid_i) begin
                if (celsius > TEMP_MAX) begin
                    reading_o <= TEMP_W'(TEMP_MAX);
                end else if (celsius < TEMP_MIN) begin
                    reading_o <= TEMP_W'(TEMP_MIN);
                end else begin
                    reading_o <= TEMP_W'(celsius);
                end
            end
        end
    end
endmodule : mas_temp_conv

/* File: rtl/mas_monitor_adc_sequencer.sv */
`timescale 1ns/1ps
// Overview of operation
// - Two trip selectors, 408 levels each
// - Comparator flag high above trip level
// - About 1% hysteresis around each setpoint from HV_HYST_MIN up
// - OV/UV select, window and glitch filter
// - Selector picks one of four sources
// - Full scale 2.048 V, attenuate above
// - Voltage inputs divide by three or one
// - High-voltage input divides by eight or four
// - Logic drives selector; three requesters served
// - Scheduled current conversions, eight-sample averaged
// - Voltage results rescaled to 2 mV/LSB
// - Raw 10 bits scaled to 13 bits
// - Result split into 8 and 5 bits
// - Host request routes, converts, latches readout
// - Three temperature channels: two external, one internal
// - Temperature reading 11-bit, 0.25 C/LSB
// - Ideality correction and offset applied
// - Resistance and beta compensation by configuration
// - Window output is B and not A
// - Filtered flag changes after 64 us
module mas_monitor_adc_sequencer
    import mas_pkg::*;
#(
    parameter int SCHED_CYC = SCHED_CYC_DEF,
    parameter logic [HV_TRIP_W-1:0] HV_HYST_MIN = HV_HYST_MIN_DEF
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // High-voltage monitor comparators
    input wire logic [HV_TRIP_W-1:0] hv_trip_a_i,
    input wire logic [HV_TRIP_W-1:0] hv_trip_b_i,
    input wire logic [1:0] hv_uv_mode_i,
    input wire logic hv_window_i,
    input wire logic hv_glitch_en_i,
    input wire logic [1:0] hv_cmp_raw_i,
    output logic [HV_TRIP_W-1:0] hv_trip_a_o,
    output logic [HV_TRIP_W-1:0] hv_trip_b_o,
    output logic [1:0] hv_hyst_en_o,
    output logic hv_mon_a_o,
    output logic hv_mon_b_o,
    // Converter and selector
    input wire logic adc_done_i,
    input wire logic [ADC_W-1:0] adc_data_i,
    output logic adc_start_o,
    output logic [1:0] conv_src_o,
    output logic [VSUB_W-1:0] vsub_sel_o,
    output logic voltage_monitor_input_div3_o,
    output logic hv_div8_o,
    // Host conversion request and readout
    input wire logic i2c_req_i,
    input wire logic [1:0] i2c_src_i,
    input wire logic [VSUB_W-1:0] i2c_vsel_i,
    input wire logic i2c_vdiv3_i,
    input wire logic i2c_hvdiv8_i,
    input wire logic rd_high_i,
    input wire logic rd_low_i,
    output logic i2c_busy_o,
    output logic i2c_done_o,
    output logic [RES_HI_W-1:0] result_high_o,
    output logic [RES_LO_W-1:0] result_low_o,
    // Trim loop request
    input wire logic trim_req_i,
    input wire logic [VSUB_W-1:0] trim_vsel_i,
    output logic trim_done_o,
    output logic [RES_W-1:0] trim_result_o,
    // Scheduled current averaging
    input wire logic [CUR_CH-1:0] sched_en_i,
    output logic [RES_W-1:0] cur_avg_hv_o,
    output logic [RES_W-1:0] cur_avg_lv_o,
    // Temperature channels, index 2 is the on-die sensor
    input wire logic [TEMP_CH-1:0] temp_valid_i,
    input wire logic signed [TRAW_W-1:0] temp_raw_i [TEMP_CH],
    input wire logic [IDEAL_W-1:0] temp_ideal_i [TEMP_CH],
    input wire logic signed [TOFS_W-1:0] temp_offset_i [TEMP_CH],
    input wire logic [1:0] temp_sensor_cfg_i [TEMP_CH],
    output logic [TEMP_CH-1:0] temp_valid_o,
    output logic signed [TEMP_W-1:0] temp_reading_o [TEMP_CH],
    output logic [TEMP_CH-1:0] beta_comp_en_o,
    output logic [TEMP_CH-1:0] series_comp_en_o
);
    typedef enum logic [1:0] {OWN_I2C, OWN_TRIM, OWN_SCHED_HV, OWN_SCHED_LV} mas_owner_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} mas_state_t;

    localparam int SCHED_W = $clog2(SCHED_CYC + 1);
    localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

    // Digital multiplier matching the attenuator in use
    function automatic logic [RES_W-1:0] mas_scale(input logic [1:0] src, input logic div3,
                                                   input logic div8, input logic [ADC_W-1:0] raw);
        logic [RES_W-1:0] wide;
        wide = RES_W'(raw);
        case (src)
            SRC_VOLTAGE_MONITOR_INPUT: mas_scale = div3 ? RES_W'(wide * 3) : wide;
            SRC_HV_MON: mas_scale = div8 ? (wide << 3) : (wide << 2);
            default: mas_scale = wide;
        endcase
    endfunction : mas_scale

    function automatic logic [HV_TRIP_W-1:0] mas_trip_clamp(input logic [HV_TRIP_W-1:0] code);
        mas_trip_clamp = (code > HV_TRIP_MAX) ? HV_TRIP_MAX : code;
    endfunction : mas_trip_clamp

    // High-voltage monitor
    logic [1:0] hv_filt;

    // Trip codes beyond the last level are held at the top level
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hv_trip_a_o <= '0;
            hv_trip_b_o <= '0;
            hv_hyst_en_o <= '0;
        end else begin
            hv_trip_a_o <= mas_trip_clamp(hv_trip_a_i);
            hv_trip_b_o <= mas_trip_clamp(hv_trip_b_i);
            hv_hyst_en_o[0] <= mas_trip_clamp(hv_trip_a_i) >= HV_HYST_MIN;
            hv_hyst_en_o[1] <= mas_trip_clamp(hv_trip_b_i) >= HV_HYST_MIN;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_hv_filt
        mas_glitch_filter u_filt (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .raw_i(hv_cmp_raw_i[g]),
            .filt_en_i(hv_glitch_en_i),
            .flag_o(hv_filt[g])
        );
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hv_mon_a_o <= 1'b0;
            hv_mon_b_o <= 1'b0;
        end else begin
            // Window needs trip A above trip B to mean anything
            hv_mon_a_o <= hv_window_i ? (hv_filt[1] & ~hv_filt[0]) : (hv_filt[0] ^ hv_uv_mode_i[0]);
            hv_mon_b_o <= hv_filt[1] ^ hv_uv_mode_i[1];
        end
    end

    // Request bookkeeping
    logic i2c_pend_reg;
    logic [1:0] i2c_src_reg;
    logic [VSUB_W-1:0] i2c_vsel_reg;
    logic i2c_vdiv3_reg;
    logic i2c_hvdiv8_reg;
    logic trim_pend_reg;
    logic [VSUB_W-1:0] trim_vsel_reg;
    logic [CUR_CH-1:0] sched_pend_reg;
    logic [SCHED_W-1:0] sched_cnt_reg;
    logic sched_tick;
    mas_state_t state_reg;
    mas_owner_t owner_reg;
    logic [SETTLE_W-1:0] settle_cnt_reg;
    logic grant;
    logic finish;
    logic [RES_W-1:0] scaled;

    assign sched_tick = (sched_cnt_reg == SCHED_W'(SCHED_CYC - 1));
    assign grant = (state_reg == ST_IDLE) && (i2c_pend_reg || trim_pend_reg || (sched_pend_reg != '0));
    assign finish = (state_reg == ST_CONV) && adc_done_i;
    assign scaled = mas_scale(conv_src_o, voltage_monitor_input_div3_o, hv_div8_o, adc_data_i);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sched_cnt_reg <= '0;
        end else begin
            sched_cnt_reg <= sched_tick ? '0 : sched_cnt_reg + 1'b1;
        end
    end

    // A request that lands while its flag is cleared stays pending
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            i2c_pend_reg <= 1'b0;
            i2c_src_reg <= SRC_HV_CUR;
            i2c_vsel_reg <= '0;
            i2c_vdiv3_reg <= 1'b0;
            i2c_hvdiv8_reg <= 1'b0;
        end else if (i2c_req_i) begin
            i2c_pend_reg <= 1'b1;
            i2c_src_reg <= i2c_src_i;
            i2c_vsel_reg <= i2c_vsel_i;
            i2c_vdiv3_reg <= i2c_vdiv3_i;
            i2c_hvdiv8_reg <= i2c_hvdiv8_i;
        end else if (grant && i2c_pend_reg) begin
            i2c_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trim_pend_reg <= 1'b0;
            trim_vsel_reg <= '0;
        end else if (trim_req_i) begin
            trim_pend_reg <= 1'b1;
            trim_vsel_reg <= trim_vsel_i;
        end else if (grant && !i2c_pend_reg) begin
            trim_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sched_pend_reg <= '0;
        end else begin
            for (int c = 0; c < CUR_CH; c++) begin
                if (sched_tick && sched_en_i[c]) begin
                    sched_pend_reg[c] <= 1'b1;
                end else if (grant && !i2c_pend_reg && !trim_pend_reg &&
                             (c == 0 || !sched_pend_reg[0])) begin
                    sched_pend_reg[c] <= 1'b0;
                end
            end
        end
    end

    // Sequencer: host first, then trim, then scheduled currents
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            owner_reg <= OWN_I2C;
            settle_cnt_reg <= '0;
            adc_start_o <= 1'b0;
            conv_src_o <= SRC_HV_CUR;
            vsub_sel_o <= '0;
            voltage_monitor_input_div3_o <= 1'b1;
            hv_div8_o <= 1'b1;
        end else begin
            adc_start_o <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    settle_cnt_reg <= '0;
                    if (grant) begin
                        state_reg <= ST_SETTLE;
                        if (i2c_pend_reg) begin
                            owner_reg <= OWN_I2C;
                            conv_src_o <= i2c_src_reg;
                            vsub_sel_o <= i2c_vsel_reg;
                            voltage_monitor_input_div3_o <= i2c_vdiv3_reg;
                            hv_div8_o <= i2c_hvdiv8_reg;
                        end else if (trim_pend_reg) begin
                            owner_reg <= OWN_TRIM;
                            conv_src_o <= SRC_VOLTAGE_MONITOR_INPUT;
                            vsub_sel_o <= trim_vsel_reg;
                            voltage_monitor_input_div3_o <= 1'b1;
                        end else if (sched_pend_reg[0]) begin
                            owner_reg <= OWN_SCHED_HV;
                            conv_src_o <= SRC_HV_CUR;
                        end else begin
                            owner_reg <= OWN_SCHED_LV;
                            conv_src_o <= SRC_LV_CUR;
                        end
                    end
                end
                ST_SETTLE: begin
                    settle_cnt_reg <= settle_cnt_reg + 1'b1;
                    if (settle_cnt_reg == SETTLE_W'(SETTLE_CYC - 1)) begin
                        adc_start_o <= 1'b1;
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (adc_done_i) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            i2c_busy_o <= 1'b0;
            i2c_done_o <= 1'b0;
            trim_done_o <= 1'b0;
            trim_result_o <= '0;
        end else begin
            i2c_busy_o <= i2c_req_i || i2c_pend_reg || (state_reg != ST_IDLE && owner_reg == OWN_I2C && !finish);
            i2c_done_o <= finish && owner_reg == OWN_I2C;
            trim_done_o <= finish && owner_reg == OWN_TRIM;
            if (finish && owner_reg == OWN_TRIM) begin
                trim_result_o <= scaled;
            end
        end
    end

    // Readout: results wait in a stash while a pair is being read
    logic rd_busy_reg;
    logic stash_vld_reg;
    logic [RES_W-1:0] stash_reg;
    logic new_res;

    assign new_res = finish && owner_reg == OWN_I2C;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_busy_reg <= 1'b0;
            stash_vld_reg <= 1'b0;
            stash_reg <= '0;
            result_high_o <= '0;
            result_low_o <= '0;
        end else begin
            if (rd_high_i) begin
                rd_busy_reg <= 1'b1;
            end else if (rd_low_i) begin
                rd_busy_reg <= 1'b0;
            end
            if (new_res && (rd_busy_reg || rd_high_i) && !rd_low_i) begin
                stash_reg <= scaled;
                stash_vld_reg <= 1'b1;
            end else if (new_res) begin
                {result_high_o, result_low_o} <= scaled;
                stash_vld_reg <= 1'b0;
            end else if (stash_vld_reg && !rd_busy_reg && !rd_high_i) begin
                {result_high_o, result_low_o} <= stash_reg;
                stash_vld_reg <= 1'b0;
            end
        end
    end

    // Eight-sample exponential average per current channel
    logic [ACC_W-1:0] acc_reg [CUR_CH];
    logic [CUR_CH-1:0] acc_init_reg;

    for (genvar c = 0; c < CUR_CH; c++) begin : g_avg
        logic hit;
        assign hit = finish && (owner_reg == (c == 0 ? OWN_SCHED_HV : OWN_SCHED_LV));
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                acc_reg[c] <= '0;
                acc_init_reg[c] <= 1'b0;
            end else if (hit) begin
                acc_init_reg[c] <= 1'b1;
                acc_reg[c] <= acc_init_reg[c] ?
                    acc_reg[c] - (acc_reg[c] >> AVG_SHIFT) + ACC_W'(scaled) :
                    (ACC_W'(scaled) << AVG_SHIFT);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_avg_hv_o <= '0;
            cur_avg_lv_o <= '0;
        end else begin
            cur_avg_hv_o <= acc_reg[0][ACC_W-1:AVG_SHIFT];
            cur_avg_lv_o <= acc_reg[1][ACC_W-1:AVG_SHIFT];
        end
    end

    // Temperature channels
    for (genvar t = 0; t < TEMP_CH; t++) begin : g_temp
        mas_temp_conv u_conv (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .sample_valid_i(temp_valid_i[t]),
            .sample_i(temp_raw_i[t]),
            .ideality_recip_i(temp_ideal_i[t]),
            .offset_i(temp_offset_i[t]),
            .valid_o(temp_valid_o[t]),
            .reading_o(temp_reading_o[t])
        );
        always_ff @(posedge clk_sys_i or negedge nrst_i) begin
            if (!nrst_i) begin
                beta_comp_en_o[t] <= 1'b0;
                series_comp_en_o[t] <= 1'b0;
            end else begin
                beta_comp_en_o[t] <= temp_sensor_cfg_i[t] == SENS_BETA_PNP;
                series_comp_en_o[t] <= temp_sensor_cfg_i[t] == SENS_BETA_PNP ||
                                       temp_sensor_cfg_i[t] == SENS_DIFF;
            end
        end
    end
endmodule : mas_monitor_adc_sequencer

/* File: dv/mas_chk.sv */
`timescale 1ns/1ps
module mas_chk
    import mas_pkg::*;
#(
    parameter logic [HV_TRIP_W-1:0] HV_HYST_MIN = HV_HYST_MIN_DEF
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Watched ports
    input wire logic [HV_TRIP_W-1:0] hv_trip_a_i,
    input wire logic [HV_TRIP_W-1:0] hv_trip_a_o,
    input wire logic [1:0] hv_hyst_en_o,
    input wire logic adc_done_i,
    input wire logic adc_start_o,
    input wire logic [1:0] conv_src_o,
    input wire logic i2c_req_i,
    input wire logic i2c_busy_o,
    input wire logic i2c_done_o,
    input wire logic trim_done_o,
    input wire logic [TEMP_CH-1:0] temp_valid_i,
    input wire logic [1:0] temp_sensor_cfg_i [TEMP_CH],
    input wire logic [TEMP_CH-1:0] temp_valid_o,
    input wire logic [TEMP_CH-1:0] beta_comp_en_o,
    input wire logic [TEMP_CH-1:0] series_comp_en_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence pulse_s; adc_start_o ##1 !adc_start_o; endsequence
    // Selector must sit still while the input settles
    sequence settled_s; conv_src_o == $past(conv_src_o, 8); endsequence
    trip_clamp_a: assert property ($past(nrst_i) |-> hv_trip_a_o ==
        ($past(hv_trip_a_i) > HV_TRIP_MAX ? HV_TRIP_MAX : $past(hv_trip_a_i))) else $error("trip code not clamped");
    hyst_band_a: assert property ($past(nrst_i) |-> hv_hyst_en_o[0] == (hv_trip_a_o >= HV_HYST_MIN))
        else $error("hysteresis enable wrong");
    start_pulse_a: assert property (adc_start_o |-> pulse_s) else $error("start not a single pulse");
    start_settle_a: assert property (adc_start_o |-> settled_s) else $error("selector moved before start");
    host_done_a: assert property (i2c_done_o |-> $past(adc_done_i)) else $error("host done without result");
    trim_done_a: assert property (trim_done_o |-> $past(adc_done_i)) else $error("trim done without result");
    req_held_a: assert property (i2c_req_i |=> i2c_busy_o) else $error("host request not held");
    temp_valid_a: assert property ($past(nrst_i) |-> temp_valid_o == $past(temp_valid_i))
        else $error("temperature valid late");
    beta_cfg_a: assert property ($past(nrst_i) |-> beta_comp_en_o[0] ==
        ($past(temp_sensor_cfg_i[0]) == SENS_BETA_PNP)) else $error("beta compensation wrong");
    series_cfg_a: assert property ($past(nrst_i) |-> series_comp_en_o[1] ==
        ($past(temp_sensor_cfg_i[1]) <= SENS_DIFF)) else $error("series compensation wrong");
endmodule : mas_chk
bind mas_monitor_adc_sequencer mas_chk #(.HV_HYST_MIN(HV_HYST_MIN)) mas_chk_inst (.*);

/* File: dv/mas_adc_model.sv */
`timescale 1ns/1ps
module mas_adc_model
    import mas_pkg::*;
(
    // Clock and converter handshake
    input wire logic clk_sys_i,
    input wire logic adc_start_o,
    input wire logic slow_i,
    input wire logic [ADC_W-1:0] code_i,
    output logic done_o,
    output logic [ADC_W-1:0] data_o
);
    int cnt = 0;
    initial {done_o, data_o} = '0;
    always @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        // Data toggles outside the done pulse so a stale sample is caught
        data_o <= ~data_o;
        if (adc_start_o) cnt <= slow_i ? 40 : 3;
        else if (cnt > 1) cnt <= cnt - 1;
        else if (cnt == 1) begin
            done_o <= 1'b1;
            data_o <= code_i;
            cnt <= 0;
        end
    end
endmodule : mas_adc_model

/* File: dv/mas_monitor_adc_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module mas_monitor_adc_sequencer_tb
    import mas_pkg::*;
;
    logic clk_sys_i = 0, nrst_i, hv_window_i, hv_glitch_en_i, adc_done_i, adc_start_o, voltage_monitor_input_div3_o, hv_div8_o;
    logic i2c_req_i, i2c_vdiv3_i, i2c_hvdiv8_i, rd_high_i, rd_low_i, i2c_busy_o, i2c_done_o, trim_req_i;
    logic trim_done_o, hv_mon_a_o, hv_mon_b_o, slow;
    logic [1:0] hv_uv_mode_i, hv_cmp_raw_i, hv_hyst_en_o, conv_src_o, i2c_src_i, sched_en_i;
    logic [HV_TRIP_W-1:0] hv_trip_a_i, hv_trip_b_i, hv_trip_a_o, hv_trip_b_o;
    logic [ADC_W-1:0] adc_data_i, code;
    logic [VSUB_W-1:0] vsub_sel_o, i2c_vsel_i, trim_vsel_i;
    logic [RES_HI_W-1:0] result_high_o;
    logic [RES_LO_W-1:0] result_low_o;
    logic [RES_W-1:0] trim_result_o, cur_avg_hv_o, cur_avg_lv_o, last, nw, ex, et;
    logic [TEMP_CH-1:0] temp_valid_i, temp_valid_o, beta_comp_en_o, series_comp_en_o;
    logic signed [TRAW_W-1:0] temp_raw_i [TEMP_CH];
    logic [IDEAL_W-1:0] temp_ideal_i [TEMP_CH];
    logic signed [TOFS_W-1:0] temp_offset_i [TEMP_CH];
    logic [1:0] temp_sensor_cfg_i [TEMP_CH];
    logic signed [TEMP_W-1:0] temp_reading_o [TEMP_CH], te;
    logic [RES_W-1:0] exp_q[$], tq[$];
    int n_fail = 0, samples_checked = 0;

    always #25 clk_sys_i = ~clk_sys_i;
    mas_monitor_adc_sequencer #(.SCHED_CYC(50)) mas_monitor_adc_sequencer_inst (.*);
    mas_adc_model mas_adc_model_inst (.clk_sys_i(clk_sys_i), .adc_start_o(adc_start_o), .slow_i(slow),
        .code_i(code), .done_o(adc_done_i), .data_o(adc_data_i));

    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    function automatic logic [RES_W-1:0] scl(input logic [1:0] s, input logic a, input logic [ADC_W-1:0] c);
        return RES_W'(c) * (s == 2'h2 ? (a ? 13'h8 : 13'h4) : s == 2'h3 && a ? 13'h3 : 13'h1);
    endfunction : scl

    task automatic conv(input logic [1:0] s, input logic a, input logic [RES_W-1:0] e);
        int n;
        {i2c_src_i, i2c_vdiv3_i, i2c_hvdiv8_i, i2c_req_i} = {s, a, a, 1'b1};
        i2c_vsel_i = VSUB_W'($urandom);
        exp_q.push_back(e);
        @(negedge clk_sys_i);
        {i2c_req_i, trim_req_i} = 2'b00;
        for (n = 0; n < 300 && i2c_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
        `CHK(conv_src_o, s)
        if (s[1]) `CHK(s[0] ? voltage_monitor_input_div3_o : hv_div8_o, a)
        `CHK({i2c_busy_o, vsub_sel_o}, {1'b0, i2c_vsel_i})
        last = e;
    endtask : conv

    // Expected results are noted by the driver and consumed here as they appear
    always @(negedge clk_sys_i) begin
        if (i2c_done_o === 1'b1) begin
            ex = exp_q.pop_front();
            `CHK({result_high_o, result_low_o}, ex)
        end
        if (trim_done_o === 1'b1) begin
            et = tq.pop_front();
            `CHK(trim_result_o, et)
        end
    end

    initial begin
        #3000000;
        n_fail++;
        finish_test;
    end

    initial begin
        {nrst_i, hv_window_i, hv_glitch_en_i, i2c_req_i, i2c_vdiv3_i, i2c_hvdiv8_i, rd_high_i, rd_low_i} = '0;
        {trim_req_i, slow, hv_uv_mode_i, hv_cmp_raw_i, i2c_src_i, sched_en_i, hv_trip_a_i, hv_trip_b_i} = '0;
        {code, i2c_vsel_i, trim_vsel_i, temp_valid_i} = '0;
        foreach (temp_raw_i[c]) begin
            {temp_raw_i[c], temp_offset_i[c], temp_sensor_cfg_i[c]} = '0;
            temp_ideal_i[c] = 16'h4000;
        end
        void'($urandom(32'h6590a28c));
        repeat (2) @(negedge clk_sys_i);
        `CHK({voltage_monitor_input_div3_o, hv_div8_o, adc_start_o}, 3'h6)
        nrst_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            code = ADC_W'($urandom);
            slow = i[0];
            conv(i[2:1], i[0], scl(i[2:1], i[0], code));
        end
        trim_vsel_i = VSUB_W'($urandom);
        trim_req_i = 1'b1;
        tq.push_back(RES_W'(code) * 13'h3);
        conv(2'h3, 1'b0, scl(2'h3, 1'b0, code));
        `CHK(tq.size(), 1)
        for (int n = 0; n < 300 && tq.size() != 0; n++) @(negedge clk_sys_i);
        `CHK(tq.size(), 0)
        rd_high_i = 1'b1;
        @(negedge clk_sys_i) rd_high_i = 1'b0;
        code = ADC_W'($urandom);
        nw = RES_W'(code);
        conv(2'h1, 1'b0, last);
        rd_low_i = 1'b1;
        @(negedge clk_sys_i) rd_low_i = 1'b0;
        @(negedge clk_sys_i);
        `CHK({result_high_o, result_low_o}, nw)
        {slow, sched_en_i} = 3'h3;
        repeat (300) @(negedge clk_sys_i);
        `CHK({cur_avg_hv_o, cur_avg_lv_o}, {nw, nw})
        sched_en_i = 2'h0;
        repeat (100) @(negedge clk_sys_i);
        for (int c = 0; c < TEMP_CH; c++) begin
            temp_raw_i[c] = (c == 2) ? 12'sh7ff : TRAW_W'($urandom_range(400)) - 12'sd200;
            temp_offset_i[c] = TOFS_W'($urandom);
            temp_sensor_cfg_i[c] = 2'(c);
            te = (c == 2) ? 11'sh3ff : TEMP_W'(temp_raw_i[c] + temp_offset_i[c]);
            temp_valid_i = TEMP_CH'(1 << c);
            @(negedge clk_sys_i) temp_valid_i = '0;
            `CHK(temp_valid_o, TEMP_CH'(1 << c))
            `CHK(temp_reading_o[c], te)
        end
        {hv_trip_a_i, hv_trip_b_i, hv_window_i, hv_cmp_raw_i} = {9'h1ff, 9'h010, 1'b1, 2'b10};
        repeat (6) @(negedge clk_sys_i);
        `CHK({hv_trip_a_o, hv_trip_b_o}, {9'h197, 9'h010})
        `CHK(hv_hyst_en_o, 2'h1)
        `CHK({hv_mon_b_o, hv_mon_a_o}, 2'h3)
        hv_cmp_raw_i = 2'b11;
        repeat (6) @(negedge clk_sys_i);
        `CHK({hv_mon_b_o, hv_mon_a_o}, 2'h2)
        {hv_glitch_en_i, hv_cmp_raw_i} = 3'h4;
        repeat (100) @(negedge clk_sys_i);
        `CHK({hv_mon_b_o, hv_mon_a_o}, 2'h2)
        repeat (1300) @(negedge clk_sys_i);
        `CHK({hv_mon_b_o, hv_mon_a_o}, 2'h0)
        hv_uv_mode_i = 2'b10;
        repeat (6) @(negedge clk_sys_i);
        `CHK({hv_mon_b_o, hv_mon_a_o}, 2'h2)
        finish_test;
    end
endmodule : mas_monitor_adc_sequencer_tb
